// file: verilog/system_control_interface_module.sv
// serial command front end: frame receiver, address filter, parser, switch timing, transmitter
// How it works
// (R01) In multidrop mode a command must open with a slash and an address, and only own-address commands act.
// (R02) The address after the slash is exactly two decimal digits compared against the configured address.
// (R03) Addresses 01 to 07 are multidrop addresses and 00 selects point-to-point mode without any prefix.
// (R04) The logic address comes from four static configuration switch inputs.
// (R05) In multidrop mode XON and XOFF also need the matching prefix or they have no effect.
// (R06) A follow switch is prefix, source letter and 1-3 digits, destination letter and 1-3 digits, then CR.
// (R07) Characters are framed as 8 data bits, one stop bit and no parity, with no option to change it.
// (R08) With a reference present the switch lands on line 10 of 525-line or line 7 of 625-line frames.
// (R09) With handshake enabled in point-to-point mode DTR and RTS are driven and DSR and CTS are watched.
// (R10) With handshake disabled only TXD, RXD and ground are used and the handshake inputs are ignored.
// (R11) Text is plain ASCII and transmission pauses on XOFF and resumes on XON.
// (R12) A command for another address is silently dropped and never answered on the line.
// (R13) Spaces between fields are not accepted and CR is the only terminator.
`timescale 1ns/1ps

module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = count_ff != (AW+1)'(DEPTH);
    assign out_valid = count_ff != '0;
    assign out_data  = mem[rd_ptr_ff];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
            count_ff  <= (AW+1)'(count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule

module system_control_interface_module (
    input  wire logic                      sys_clk,
    input  wire logic                      resetn,
    input  wire logic                      rxd,
    output logic                           txd,
    output logic                           dtr,
    output logic                           rts,
    input  wire logic                      dsr,
    input  wire logic                      cts,
    input  wire logic [3:0]                address_config_switch_bank,
    input  wire logic                      hs_enable,
    input  wire logic                      ref_present,
    input  wire logic                      ref_vsync,
    input  wire logic                      ref_hsync,
    input  wire logic                      ref_625,
    input  wire logic                      tx_valid,
    output logic                           tx_ready,
    input  wire logic [7:0]                tx_data,
    output logic                           sw_valid,
    output front_end_pkg::switch_cmd_s     sw_cmd,
    output logic                           p2p_mode
);
    function automatic logic is_digit(input logic [7:0] c);
        return c >= front_end_pkg::CH_ZERO && c <= front_end_pkg::CH_NINE;
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    front_end_pkg::pins_s raw_pins;
    front_end_pkg::pins_s pin;
    logic [11:0] s1_ff;
    logic [11:0] s2_ff;
    logic [11:0] s3_ff;
    logic [11:0] filt_ff;

    assign raw_pins = '{rxd, dsr, cts, ref_present, ref_vsync, ref_hsync, ref_625, hs_enable,
                        address_config_switch_bank};
    assign pin      = filt_ff;

    // (R04) address switches sampled
    for (genvar i = 0; i < 12; i++) begin : g_sync
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                s1_ff[i]   <= front_end_pkg::PIN_RST[i];
                s2_ff[i]   <= front_end_pkg::PIN_RST[i];
                s3_ff[i]   <= front_end_pkg::PIN_RST[i];
                filt_ff[i] <= front_end_pkg::PIN_RST[i];
            end else begin
                s1_ff[i]   <= raw_pins[i];
                s2_ff[i]   <= s1_ff[i];
                s3_ff[i]   <= s2_ff[i];
                filt_ff[i] <= (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : filt_ff[i];
            end
        end
    end

    wire [3:0] my_addr   = pin.address_config_switch_bank;
    // (R03) address zero means point-to-point
    wire       p2p       = my_addr == front_end_pkg::ADDR_P2P;
    // (R09) handshake lines only in point-to-point
    wire       hs_active = p2p && pin.hs_enable;

    // ---------------------------------------------------------------
    // receiver
    // ---------------------------------------------------------------
    front_end_pkg::rx_e rx_st_ff;
    logic [9:0] rx_cnt_ff;
    logic [3:0] rx_bits_ff;
    logic [7:0] rx_sh_ff;
    logic       rx_vld_ff;
    logic [7:0] rx_char_ff;
    wire        rx_tick = rx_cnt_ff == '0;

    // (R07) fixed 8N1 frame, stop bit checked
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_st_ff   <= front_end_pkg::RX_IDLE;
            rx_cnt_ff  <= '0;
            rx_bits_ff <= '0;
            rx_sh_ff   <= '0;
            rx_vld_ff  <= 1'b0;
            rx_char_ff <= '0;
        end else begin
            rx_vld_ff <= 1'b0;
            rx_cnt_ff <= rx_tick ? 10'(front_end_pkg::BIT_CYC - 1'b1) : 10'(rx_cnt_ff - 1'b1);
            case (rx_st_ff)
                front_end_pkg::RX_IDLE: begin
                    rx_cnt_ff <= front_end_pkg::HALF_CYC;
                    if (!pin.rxd) begin
                        rx_st_ff <= front_end_pkg::RX_START;
                    end
                end
                front_end_pkg::RX_START: begin
                    if (rx_tick) begin
                        rx_st_ff   <= pin.rxd ? front_end_pkg::RX_IDLE : front_end_pkg::RX_DATA;
                        rx_bits_ff <= '0;
                    end
                end
                front_end_pkg::RX_DATA: begin
                    if (rx_tick) begin
                        rx_sh_ff   <= {pin.rxd, rx_sh_ff[7:1]};
                        rx_bits_ff <= 4'(rx_bits_ff + 1'b1);
                        if (rx_bits_ff == 4'(front_end_pkg::DATA_BITS - 1'b1)) begin
                            rx_st_ff <= front_end_pkg::RX_STOP;
                        end
                    end
                end
                default: begin
                    if (rx_tick) begin
                        rx_vld_ff  <= pin.rxd;
                        rx_char_ff <= rx_sh_ff;
                        rx_st_ff   <= front_end_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // command parser
    // ---------------------------------------------------------------
    front_end_pkg::parse_e st_ff;
    front_end_pkg::parse_e nxt_st;
    logic [3:0] hi_ff;
    logic [3:0] nxt_hi;
    logic [9:0] acc_ff;
    logic [9:0] nxt_acc;
    logic [9:0] src_ff;
    logic [9:0] nxt_src;
    logic [1:0] dcnt_ff;
    logic [1:0] nxt_dcnt;
    logic       nxt_fire;

    wire [7:0] c         = rx_char_ff;
    wire       dig       = is_digit(c);
    wire [3:0] dval      = c[3:0];
    wire       is_cr     = c == front_end_pkg::CH_CR;
    wire       is_flow   = c == front_end_pkg::CH_XON || c == front_end_pkg::CH_XOFF;
    // (R05) flow control needs the prefix in multidrop
    wire       flow_hit  = rx_vld_ff && is_flow && (p2p || st_ff == front_end_pkg::PS_BODY);
    wire       room      = dcnt_ff != front_end_pkg::MAX_DIGITS;
    wire       addr_ok   = hi_ff == 4'h0 && dig && dval == my_addr
                           && my_addr <= front_end_pkg::ADDR_MAX;
    wire [9:0] acc_step  = 10'(acc_ff * 10'h00A + {6'h00, dval});

    always_comb begin
        nxt_st   = st_ff;
        nxt_hi   = hi_ff;
        nxt_acc  = acc_ff;
        nxt_src  = src_ff;
        nxt_dcnt = dcnt_ff;
        nxt_fire = 1'b0;
        if (rx_vld_ff) begin
            // (R13) carriage return is the only terminator
            if (is_cr) begin
                nxt_fire = st_ff == front_end_pkg::PS_DST_NUM && dcnt_ff != 2'h0;
                nxt_st   = front_end_pkg::PS_START;
                nxt_acc  = '0;
                nxt_dcnt = '0;
            end else if (flow_hit) begin
                nxt_st = p2p ? st_ff : front_end_pkg::PS_START;
            end else begin
                case (st_ff)
                    // (R01) prefix required in multidrop
                    front_end_pkg::PS_START: begin
                        if (!p2p) begin
                            nxt_st = (c == front_end_pkg::CH_SLASH) ? front_end_pkg::PS_ADDR_HI
                                                                  : front_end_pkg::PS_SKIP;
                        end else begin
                            nxt_st = (c == front_end_pkg::CH_SRC) ? front_end_pkg::PS_SRC_NUM
                                                                : front_end_pkg::PS_SKIP;
                        end
                    end
                    // (R02) exactly two address digits
                    front_end_pkg::PS_ADDR_HI: begin
                        nxt_hi = dval;
                        nxt_st = dig ? front_end_pkg::PS_ADDR_LO : front_end_pkg::PS_SKIP;
                    end
                    // (R12) foreign address silently skipped
                    front_end_pkg::PS_ADDR_LO: begin
                        nxt_st = addr_ok ? front_end_pkg::PS_BODY : front_end_pkg::PS_SKIP;
                    end
                    front_end_pkg::PS_BODY: begin
                        nxt_st = (c == front_end_pkg::CH_SRC) ? front_end_pkg::PS_SRC_NUM
                                                            : front_end_pkg::PS_SKIP;
                    end
                    // (R06) source and destination numbers
                    front_end_pkg::PS_SRC_NUM: begin
                        if (dig && room) begin
                            nxt_acc  = acc_step;
                            nxt_dcnt = 2'(dcnt_ff + 1'b1);
                        end else if (c == front_end_pkg::CH_DST && dcnt_ff != 2'h0) begin
                            nxt_src  = acc_ff;
                            nxt_acc  = '0;
                            nxt_dcnt = '0;
                            nxt_st   = front_end_pkg::PS_DST_NUM;
                        end else begin
                            nxt_st = front_end_pkg::PS_SKIP;
                        end
                    end
                    front_end_pkg::PS_DST_NUM: begin
                        if (dig && room) begin
                            nxt_acc  = acc_step;
                            nxt_dcnt = 2'(dcnt_ff + 1'b1);
                        end else begin
                            nxt_st = front_end_pkg::PS_SKIP;
                        end
                    end
                    default: nxt_st = st_ff;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff   <= front_end_pkg::PS_START;
            hi_ff   <= '0;
            acc_ff  <= '0;
            src_ff  <= '0;
            dcnt_ff <= '0;
        end else begin
            st_ff   <= nxt_st;
            hi_ff   <= nxt_hi;
            acc_ff  <= nxt_acc;
            src_ff  <= nxt_src;
            dcnt_ff <= nxt_dcnt;
        end
    end

    // ---------------------------------------------------------------
    // switch timing against the reference
    // ---------------------------------------------------------------
    logic        vs_q_ff;
    logic        hs_q_ff;
    logic [9:0]  line_ff;
    logic        pend_ff;
    front_end_pkg::switch_cmd_s pcmd_ff;
    logic        sw_valid_ff;
    front_end_pkg::switch_cmd_s sw_cmd_ff;

    wire       vs_rise  = pin.ref_vsync && !vs_q_ff;
    wire       hs_rise  = pin.ref_hsync && !hs_q_ff;
    wire [9:0] target   = pin.ref_625 ? front_end_pkg::LINE_625 : front_end_pkg::LINE_525;
    // (R08) release only at the start of the target line
    wire       line_hit = hs_rise && line_ff == 10'(target - 1'b1);
    wire       go       = pend_ff && (!pin.ref_present || line_hit);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            vs_q_ff     <= 1'b0;
            hs_q_ff     <= 1'b0;
            line_ff     <= '0;
            pend_ff     <= 1'b0;
            pcmd_ff     <= '0;
            sw_valid_ff <= 1'b0;
            sw_cmd_ff   <= '0;
        end else begin
            vs_q_ff     <= pin.ref_vsync;
            hs_q_ff     <= pin.ref_hsync;
            line_ff     <= vs_rise ? 10'h001 : (hs_rise ? 10'(line_ff + 1'b1) : line_ff);
            // a new command arriving as the old one fires stays pending
            pend_ff     <= nxt_fire || (pend_ff && !go);
            pcmd_ff     <= nxt_fire ? front_end_pkg::switch_cmd_s'{nxt_src, acc_ff} : pcmd_ff;
            sw_valid_ff <= go;
            sw_cmd_ff   <= go ? pcmd_ff : sw_cmd_ff;
        end
    end

    // ---------------------------------------------------------------
    // flow control and transmitter
    // ---------------------------------------------------------------
    logic       xoff_ff;
    logic       hs_ff;
    logic       tx_busy_ff;
    logic [9:0] tx_cnt_ff;
    logic [3:0] tx_bits_ff;
    logic [7:0] tx_sh_ff;
    logic       txd_ff;
    logic       f_valid;
    logic [7:0] f_data;

    // (R10) handshake inputs ignored unless enabled
    wire tx_allow = !xoff_ff && (!hs_active || (pin.cts && pin.dsr));
    // (R11) a paused transmitter stalls the buffer
    wire tx_start = f_valid && tx_allow && !tx_busy_ff;
    wire tx_tick  = tx_cnt_ff == '0;

    sync_fifo #(
        .WIDTH (front_end_pkg::FIFO_WIDTH),
        .DEPTH (front_end_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (f_valid),
        .out_ready (tx_start),
        .out_data  (f_data)
    );

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            xoff_ff    <= 1'b0;
            hs_ff      <= 1'b0;
            tx_busy_ff <= 1'b0;
            tx_cnt_ff  <= '0;
            tx_bits_ff <= '0;
            tx_sh_ff   <= '0;
            txd_ff     <= front_end_pkg::TXD_IDLE;
        end else begin
            xoff_ff <= flow_hit ? (c == front_end_pkg::CH_XOFF) : xoff_ff;
            hs_ff   <= hs_active;
            if (tx_start) begin
                tx_busy_ff <= 1'b1;
                txd_ff     <= 1'b0;
                tx_sh_ff   <= f_data;
                tx_bits_ff <= 4'(front_end_pkg::DATA_BITS + front_end_pkg::STOP_BITS);
                tx_cnt_ff  <= 10'(front_end_pkg::BIT_CYC - 1'b1);
            end else if (tx_busy_ff) begin
                tx_cnt_ff <= tx_tick ? 10'(front_end_pkg::BIT_CYC - 1'b1) : 10'(tx_cnt_ff - 1'b1);
                if (tx_tick) begin
                    tx_busy_ff <= tx_bits_ff != 4'h0;
                    txd_ff     <= (tx_bits_ff == 4'h0) ? front_end_pkg::TXD_IDLE : tx_sh_ff[0];
                    tx_sh_ff   <= {front_end_pkg::TXD_IDLE, tx_sh_ff[7:1]};
                    tx_bits_ff <= (tx_bits_ff == 4'h0) ? 4'h0 : 4'(tx_bits_ff - 1'b1);
                end
            end
        end
    end

    assign txd      = txd_ff;
    assign dtr      = hs_ff;
    assign rts      = hs_ff;
    assign sw_valid = sw_valid_ff;
    assign sw_cmd   = sw_cmd_ff;
    assign p2p_mode = p2p;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    prefix_needed_a: assert property ( // R01
        rx_vld_ff && !p2p && st_ff == front_end_pkg::PS_START && !is_cr
        && c != front_end_pkg::CH_SLASH |=> st_ff == front_end_pkg::PS_SKIP)
        else $error("multidrop command without slash accepted");
    two_digit_a: assert property ( // R02
        rx_vld_ff && st_ff == front_end_pkg::PS_ADDR_LO && !is_cr
        |=> st_ff inside {front_end_pkg::PS_BODY, front_end_pkg::PS_SKIP})
        else $error("address field not closed after two digits");
    p2p_no_prefix_a: assert property ( // R03
        rx_vld_ff && p2p && st_ff == front_end_pkg::PS_START && c == front_end_pkg::CH_SRC
        |=> st_ff == front_end_pkg::PS_SRC_NUM)
        else $error("point-to-point command not parsed without prefix");
    flow_prefix_a: assert property ( // R05
        rx_vld_ff && !p2p && is_flow && st_ff != front_end_pkg::PS_BODY |=> $stable(xoff_ff))
        else $error("unprefixed flow control changed state");
    frame_timing_a: assert property ( // R07
        tx_start |=> !txd [*8])
        else $error("start bit not held");
    ref_line_a: assert property ( // R08
        sw_valid && pin.ref_present |-> line_ff == target)
        else $error("switch released off the target line");
    hs_drive_a: assert property ( // R09
        hs_active |=> dtr && rts)
        else $error("handshake outputs not driven");
    hs_ignore_a: assert property ( // R10
        !hs_active && !xoff_ff && f_valid && !tx_busy_ff |-> tx_start)
        else $error("handshake inputs gated transmission");
    xoff_pause_a: assert property ( // R11
        xoff_ff && !tx_busy_ff |=> txd)
        else $error("transmission started while paused");
    foreign_drop_a: assert property ( // R12
        rx_vld_ff && !is_cr && st_ff == front_end_pkg::PS_ADDR_LO && !addr_ok
        |=> st_ff == front_end_pkg::PS_SKIP)
        else $error("foreign address command not dropped");
    space_reject_a: assert property ( // R13
        rx_vld_ff && c == 8'h20 && st_ff == front_end_pkg::PS_SRC_NUM
        |=> st_ff == front_end_pkg::PS_SKIP)
        else $error("space inside command accepted");

    switch_seen_c: cover property (sw_valid && pin.ref_present);
    pause_seen_c:  cover property ($fell(xoff_ff) && tx_start);
    foreign_c:     cover property (rx_vld_ff && st_ff == front_end_pkg::PS_ADDR_LO && !addr_ok);
    fifo_full_c:   cover property (!tx_ready);
endmodule

// file: verilog/front_end_pkg.sv
// constants and carrier types for the addressed serial command front end
package front_end_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ    = 40000000;
    localparam int unsigned BAUD_RATE = 57600;
    localparam logic [9:0]  BIT_CYC   = 10'(CLK_HZ / BAUD_RATE);
    localparam logic [9:0]  HALF_CYC  = 10'(CLK_HZ / BAUD_RATE / 2);

    // ---------------------------------------------------------------
    // character frame and parser
    // ---------------------------------------------------------------
    localparam logic [3:0] DATA_BITS  = 4'h8;
    localparam logic [3:0] STOP_BITS  = 4'h1;
    localparam logic [1:0] MAX_DIGITS = 2'h3;
    localparam logic [7:0] CH_SLASH   = 8'h2F;
    localparam logic [7:0] CH_CR      = 8'h0D;
    localparam logic [7:0] CH_XON     = 8'h11;
    localparam logic [7:0] CH_XOFF    = 8'h13;
    localparam logic [7:0] CH_SRC     = 8'h49;
    localparam logic [7:0] CH_DST     = 8'h4F;
    localparam logic [7:0] CH_ZERO    = 8'h30;
    localparam logic [7:0] CH_NINE    = 8'h39;
    localparam logic [3:0] ADDR_P2P   = 4'h0;
    localparam logic [3:0] ADDR_MAX   = 4'h7;

    // ---------------------------------------------------------------
    // reference timing and buffering
    // ---------------------------------------------------------------
    localparam logic [9:0] LINE_525   = 10'h00A;
    localparam logic [9:0] LINE_625   = 10'h007;
    localparam int         FIFO_DEPTH = 8;
    localparam int         FIFO_WIDTH = 8;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [11:0] PIN_RST   = 12'h800;
    localparam logic        TXD_IDLE  = 1'b1;

    typedef struct packed {
        logic       rxd;
        logic       dsr;
        logic       cts;
        logic       ref_present;
        logic       ref_vsync;
        logic       ref_hsync;
        logic       ref_625;
        logic       hs_enable;
        logic [3:0] address_config_switch_bank;
    } pins_s;

    typedef struct packed {
        logic [9:0] src;
        logic [9:0] dst;
    } switch_cmd_s;

    typedef enum logic [2:0] {
        PS_START, PS_ADDR_HI, PS_ADDR_LO, PS_BODY, PS_SRC_NUM, PS_DST_NUM, PS_SKIP
    } parse_e;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_e;

endpackage

// file: verif/host_terminal.sv
// host terminal model: drives rxd, decodes txd, keeps handshake lines ready
`timescale 1ns/1ps

module host_terminal (
    input  wire logic sys_clk,
    output logic      rxd,
    input  wire logic txd,
    output logic      dsr,
    output logic      cts
);
    logic [7:0] rx_byte  = 8'h00;
    int         rx_count = 0;

    // the host is always ready, so only the device side can stall
    assign dsr = 1'b1;
    assign cts = 1'b1;
    initial rxd = 1'b1;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge sys_clk);
            rxd = frame[i];
            repeat (front_end_pkg::BIT_CYC - 1) @(negedge sys_clk);
        end
    endtask

    always begin
        @(negedge txd);
        repeat (front_end_pkg::HALF_CYC) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (front_end_pkg::BIT_CYC) @(posedge sys_clk);
            rx_byte[i] = txd;
        end
        repeat (front_end_pkg::BIT_CYC) @(posedge sys_clk);
        // a low stop bit is a broken frame and is not counted
        if (txd === 1'b1) rx_count++;
    end
endmodule

// file: verif/tb.sv
// self-checking bench for the serial command front end
`timescale 1ns/1ps

module tb;
    logic                       sys_clk;
    logic                       resetn    = 1'b0;
    logic                       hs_enable = 1'b1;
    logic                       tx_valid  = 1'b0;
    logic [7:0]                 tx_data   = 8'h00;
    logic [3:0]                 addr_sw   = 4'h2;
    logic                       ref_present = 1'b1;
    logic                       ref_vsync   = 1'b0;
    logic                       ref_hsync   = 1'b0;
    logic                       rxd, txd, dtr, rts, dsr, cts, tx_ready, sw_valid, p2p_mode;
    front_end_pkg::switch_cmd_s sw_cmd;
    logic [19:0]                sw_seen   = 20'h00000;
    int                         mismatches = 0;
    int                         check_count = 0;
    int                         sw_pulses = 0;
    // rows: command text, total switch pulses so far, pulses before the target line, last switch seen
    string                      row_cmd[2]    = '{"/02I1O2\015", "/03\015"};
    int                         row_pulses[2] = '{1, 1};
    int                         row_pre[2]    = '{0, 1};
    logic [19:0]                row_sw[2]     = '{20'h00402, 20'h00402};

    host_terminal host (.sys_clk(sys_clk), .rxd(rxd), .txd(txd), .dsr(dsr), .cts(cts));

    system_control_interface_module uut (
        .sys_clk(sys_clk), .resetn(resetn), .rxd(rxd), .txd(txd), .dtr(dtr), .rts(rts),
        .dsr(dsr), .cts(cts), .address_config_switch_bank(addr_sw), .hs_enable(hs_enable),
        .ref_present(ref_present), .ref_vsync(ref_vsync), .ref_hsync(ref_hsync), .ref_625(1'b0),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .sw_valid(sw_valid), .sw_cmd(sw_cmd), .p2p_mode(p2p_mode)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic push(input logic [7:0] b);
        @(negedge sys_clk);
        tx_valid = 1'b1;
        tx_data = b;
        @(negedge sys_clk);
        tx_valid = 1'b0;
    endtask

    // one reference pulse, long enough to pass the pin filter
    task automatic ref_pulse(input logic vs);
        @(negedge sys_clk);
        if (vs) ref_vsync = 1'b1;
        else ref_hsync = 1'b1;
        repeat (6) @(negedge sys_clk);
        ref_vsync = 1'b0;
        ref_hsync = 1'b0;
        repeat (5) @(negedge sys_clk);
    endtask

    always @(negedge sys_clk) begin
        if (sw_valid === 1'b1) begin
            sw_pulses++;
            sw_seen = sw_cmd;
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // fourteen received characters of 6940 cycles each, with margin
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (5) @(negedge sys_clk);
        check("txd", txd, 1);
        check("dtr", dtr, 0);
        check("sw_valid", sw_valid, 0);
        check("tx_ready", tx_ready, 1);
        resetn = 1'b1;
        repeat (10) @(negedge sys_clk);
        check("p2p_mode", p2p_mode, 0);
        check("rts", rts, 0);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < row_cmd[r].len(); i++) host.send_byte(row_cmd[r][i]);
            ref_pulse(1'b1);
            repeat (8) ref_pulse(1'b0);
            check("sw_held", sw_pulses, row_pre[r]);
            ref_pulse(1'b0);
            check("sw_pulses", sw_pulses, row_pulses[r]);
            check("sw_cmd", sw_seen, row_sw[r]);
        end
        addr_sw = 4'h0;
        repeat (10) @(negedge sys_clk);
        check("p2p_mode", p2p_mode, 1);
        check("dtr", dtr, 1);
        check("rts", rts, 1);
        push(8'hA5);
        host.send_byte(front_end_pkg::CH_XOFF);
        check("rx_byte", host.rx_byte, 8'hA5);
        for (int i = 0; i < 8; i++) push(8'h41 + 8'(i));
        check("tx_ready", tx_ready, 0);
        repeat (700) @(negedge sys_clk);
        check("rx_count", host.rx_count, 1);
        check("txd", txd, 1);
        check("tx_ready", tx_ready, 0);
        host.send_byte(front_end_pkg::CH_XON);
        check("txd", txd, 0);
        check("tx_ready", tx_ready, 1);
        finish_test();
    end
endmodule
